// *** verilog/swnm_defines.svh ***
// Purpose: constants shared by both ends of the serial word memory link
// Assumes: system clock 10 MHz, link clock at its 100 kHz ceiling
// Notes: mode codes are {line 1, line 2, line 3}
`ifndef SWNM_DEFINES_SVH
`define SWNM_DEFINES_SVH

`define SWNM_MODE_STBY 3'h7
`define SWNM_MODE_ERASE 3'h1
`define SWNM_MODE_WRITE 3'h2
`define SWNM_MODE_SDO 3'h3
`define SWNM_MODE_SETUP 3'h0
`define SWNM_MODE_AIN 3'h4
`define SWNM_MODE_DIN 3'h5
`define SWNM_MODE_READ 3'h6

`define SWNM_AW 5
`define SWNM_DW 16
`define SWNM_WORDS 21
`define SWNM_LAST_ADDR 5'h14
`define SWNM_LFSR_SEED 16'hACE1
`define SWNM_LFSR_TAPS 16'hB400

`define SWNM_CLK_MHZ 10
`define SWNM_LCLK_KHZ 100
`define SWNM_ERASE_US 300000
`define SWNM_WRITE_US 4000
`define SWNM_HALF_CYC (`SWNM_CLK_MHZ * 1000 / (2 * `SWNM_LCLK_KHZ))
`define SWNM_AIN_CLKS 5
`define SWNM_WORD_CLKS 16

`define SWNM_REG_CTRL 3'h0
`define SWNM_REG_ADDR 3'h1
`define SWNM_REG_WDATA 3'h2
`define SWNM_REG_RDATA 3'h3
`define SWNM_REG_STAT 3'h4
`define SWNM_OP_READ 2'h0
`define SWNM_OP_EW 2'h1
`define SWNM_OP_ERASE 2'h2

`endif

// *** verilog/swnm_pkg.sv ***
// Purpose: types shared by both ends
// Assumes: constants come from swnm_defines.svh
// Notes: none
`include "swnm_defines.svh"
package swnm_pkg;
    typedef logic [2:0] swnm_mode_t;
    typedef logic [`SWNM_AW-1:0] swnm_addr_t;
    typedef logic [`SWNM_DW-1:0] swnm_word_t;
    typedef enum logic [1:0] {
        SWNM_D_IDLE,
        SWNM_D_ARMED,
        SWNM_D_ERASED,
        SWNM_D_REARMED
    } swnm_dstate_t;
    typedef enum logic [3:0] {
        SWNM_H_IDLE,
        SWNM_H_AIN,
        SWNM_H_READ,
        SWNM_H_SDO,
        SWNM_H_DIN,
        SWNM_H_SET1,
        SWNM_H_ERASE,
        SWNM_H_SET2,
        SWNM_H_WRITE
    } swnm_hstate_t;
endpackage

// *** verilog/swnm_link_if.sv ***
// Purpose: pins between host controller and memory device
// Assumes: the data line idles high through the device pull-up or bus hold
// Notes: io is the resolved line level; nobody drives it as a port
`timescale 1ns/1ps
interface swnm_link_if;
    import swnm_pkg::*;
    swnm_mode_t mode_sel;
    logic lclk;
    logic host_io_o;
    logic host_io_oe;
    logic dev_io_o;
    logic dev_io_oe;
    logic dev_pull_en;
    logic io;

    // An undriven line floats high, pulled or not
    assign io = dev_io_oe ? dev_io_o : (host_io_oe ? host_io_o : 1'b1);

    modport host (
        output mode_sel,
        output lclk,
        output host_io_o,
        output host_io_oe,
        input io
    );
    modport dev (
        input mode_sel,
        input lclk,
        output dev_io_o,
        output dev_io_oe,
        output dev_pull_en,
        input io
    );
endinterface

// *** verilog/swnm_dev.sv ***
// Purpose: memory end of the serial word link, 21 words of 16 bits
// Assumes: mode lines, link clock and data line are asynchronous pins
// Notes: acts on the synchronised rising edge of the link clock, erase on the synchronised mode alone
// Function
// - Three mode lines select eight instructions
// - Host keeps clock running within limits
// - Pull-up only in address-in and data-in
// - Drive push-pull in data-out and read, else high-Z
// - Five address bits shifted in MSB first
// - Host uses addresses 0 through 20
// - Read clock loads addressed word in parallel
// - Data-out shifts 16 bits, first in first
// - Held data-out recirculates same word
// - Data-in shifts 16 bits into register
// - Host: setup, erase, setup, write timing
// - Erase touches only addressed word
// - Host erases before every write
// - Erased unwritten word reads undefined pattern
// - Standby: line high-Z, clock ignored
// - Erase always bracketed by setups
// - Host may pre-erase several words
// - No setup/erase/write at power switching
// - Read drives the data line actively
`timescale 1ns/1ps
`include "swnm_defines.svh"
module swnm_dev (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Link
    swnm_link_if.dev link,
    // Status
    output swnm_pkg::swnm_addr_t cur_addr,
    output logic armed,
    output logic erase_pulse,
    output logic write_pulse
);
    import swnm_pkg::*;

    swnm_mode_t m_s1_q;
    swnm_mode_t m_s2_q;
    swnm_mode_t m_s3_q;
    swnm_mode_t mode_q;
    logic c_s1_q;
    logic c_s2_q;
    logic c_s3_q;
    logic clk_lvl_q;
    logic d_s1_q;
    logic d_s2_q;
    logic d_s3_q;
    logic din_lvl_q;
    logic rise;
    swnm_addr_t addr_q;
    swnm_word_t din_q;
    swnm_word_t out_q;
    swnm_word_t lfsr_q;
    swnm_word_t mem_q [0:`SWNM_WORDS-1];
    logic [`SWNM_WORDS-1:0] erased_q;
    swnm_dstate_t st_q;
    logic addr_ok;
    logic do_erase;
    logic do_write;
    logic erase_pulse_q;
    logic write_pulse_q;
    logic io_o_q;

    // Pin synchronisers; only the second and third stages are looked at
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_s1_q <= `SWNM_MODE_STBY;
            m_s2_q <= `SWNM_MODE_STBY;
            m_s3_q <= `SWNM_MODE_STBY;
            c_s1_q <= 1'b0;
            c_s2_q <= 1'b0;
            c_s3_q <= 1'b0;
            d_s1_q <= 1'b1;
            d_s2_q <= 1'b1;
            d_s3_q <= 1'b1;
        end else begin
            m_s1_q <= link.mode_sel;
            m_s2_q <= m_s1_q;
            m_s3_q <= m_s2_q;
            c_s1_q <= link.lclk;
            c_s2_q <= c_s1_q;
            c_s3_q <= c_s2_q;
            d_s1_q <= link.io;
            d_s2_q <= d_s1_q;
            d_s3_q <= d_s2_q;
        end
    end

    // A change counts once two stages agree, so a glitch of one clk sample never acts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= `SWNM_MODE_STBY;
            clk_lvl_q <= 1'b0;
            din_lvl_q <= 1'b1;
        end else begin
            if (m_s2_q == m_s3_q) begin
                mode_q <= m_s3_q;
            end
            if (c_s2_q == c_s3_q) begin
                clk_lvl_q <= c_s3_q;
            end
            if (d_s2_q == d_s3_q) begin
                din_lvl_q <= d_s3_q;
            end
        end
    end

    assign rise = (c_s2_q == c_s3_q) && c_s3_q && !clk_lvl_q;
    assign addr_ok = (addr_q <= `SWNM_LAST_ADDR);

    // Erase needs no clock, only the setup that armed it
    assign do_erase = (mode_q == `SWNM_MODE_ERASE) && (st_q == SWNM_D_ARMED);
    assign do_write = rise && (mode_q == `SWNM_MODE_WRITE) &&
        ((st_q == SWNM_D_ARMED) || (st_q == SWNM_D_REARMED));

    // Address shift register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= '0;
        end else if (rise && mode_q == `SWNM_MODE_AIN) begin
            addr_q <= {addr_q[`SWNM_AW-2:0], din_lvl_q};
        end
    end

    // Write data shift register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            din_q <= '0;
        end else if (rise && mode_q == `SWNM_MODE_DIN) begin
            din_q <= {din_q[`SWNM_DW-2:0], din_lvl_q};
        end
    end

    // Output shift register: load on read, rotate on data out
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_q <= '0;
        end else if (rise && mode_q == `SWNM_MODE_READ) begin
            out_q <= addr_ok ? mem_q[addr_q] : lfsr_q;
        end else if (rise && mode_q == `SWNM_MODE_SDO) begin
            // Rotation brings the word back after 16 bits, no array access
            out_q <= {out_q[`SWNM_DW-2:0], out_q[`SWNM_DW-1]};
        end
    end

    // Free-running pattern source for erased cells
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lfsr_q <= `SWNM_LFSR_SEED;
        end else begin
            lfsr_q <= {1'b0, lfsr_q[`SWNM_DW-1:1]} ^
                (lfsr_q[0] ? `SWNM_LFSR_TAPS : 16'h0000);
        end
    end

    // Setup sequencing; standby clocks leave it untouched
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= SWNM_D_IDLE;
        end else if (do_erase) begin
            st_q <= SWNM_D_ERASED;
        end else if (rise) begin
            case (mode_q)
                `SWNM_MODE_SETUP: begin
                    st_q <= (st_q == SWNM_D_ERASED) ? SWNM_D_REARMED : SWNM_D_ARMED;
                end
                `SWNM_MODE_STBY: begin
                    st_q <= st_q;
                end
                `SWNM_MODE_ERASE: begin
                    st_q <= st_q;
                end
                `SWNM_MODE_WRITE: begin
                    // One write per setup; later write clocks do nothing
                    st_q <= SWNM_D_IDLE;
                end
                default: begin
                    st_q <= SWNM_D_IDLE;
                end
            endcase
        end
    end

    // Array has no reset: its contents are meant to survive one
    always_ff @(posedge clk) begin
        if (do_erase && addr_ok) begin
            mem_q[addr_q] <= lfsr_q;
        end else if (do_write && addr_ok) begin
            // Writing over unerased cells ORs the new word into the old one
            mem_q[addr_q] <= erased_q[addr_q] ? din_q : (mem_q[addr_q] | din_q);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            erased_q <= '0;
        end else if (do_erase && addr_ok) begin
            erased_q[addr_q] <= 1'b1;
        end else if (do_write && addr_ok) begin
            erased_q[addr_q] <= 1'b0;
        end
    end

    // Line driver
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            io_o_q <= 1'b0;
        end else begin
            io_o_q <= out_q[`SWNM_DW-1];
        end
    end

    assign link.dev_io_o = io_o_q;
    assign link.dev_io_oe = (mode_q == `SWNM_MODE_SDO) ||
        (mode_q == `SWNM_MODE_READ);
    assign link.dev_pull_en = (mode_q == `SWNM_MODE_AIN) ||
        (mode_q == `SWNM_MODE_DIN);

    // Status
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            erase_pulse_q <= 1'b0;
            write_pulse_q <= 1'b0;
        end else begin
            erase_pulse_q <= do_erase;
            write_pulse_q <= do_write;
        end
    end

    assign cur_addr = addr_q;
    assign armed = (st_q == SWNM_D_ARMED) || (st_q == SWNM_D_REARMED);
    assign erase_pulse = erase_pulse_q;
    assign write_pulse = write_pulse_q;
endmodule

// *** verilog/swnm_host.sv ***
// Purpose: host controller end: runs read, erase-write and erase sequences
// Assumes: software uses the plain register port, read data one cycle later
// Notes: link clock made by dividing clk, held low while idle
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "swnm_defines.svh"
module swnm_host #(
    parameter int unsigned ERASE_CYC = `SWNM_ERASE_US * `SWNM_CLK_MHZ,
    parameter int unsigned WRITE_CYC = `SWNM_WRITE_US * `SWNM_CLK_MHZ
) (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Link
    swnm_link_if.host link
);
    import swnm_pkg::*;

    localparam logic [6:0] HALF_M1 = 7'(`SWNM_HALF_CYC - 1);

    swnm_hstate_t st_q;
    swnm_hstate_t st_d;
    swnm_mode_t mode_q;
    logic [1:0] op_q;
    swnm_addr_t addr_q;
    swnm_word_t wd_q;
    swnm_word_t rd_q;
    swnm_word_t sh_q;
    logic [15:0] rdata_q;
    logic [6:0] div_q;
    logic lclk_q;
    logic [4:0] bit_q;
    logic [21:0] tmr_q;
    logic [4:0] len;
    logic i_s1_q;
    logic i_s2_q;
    logic i_s3_q;
    logic io_lvl_q;
    logic run;
    logic tick;
    logic rise_t;
    logic fall_t;
    logic last;
    logic start;

    assign run = (st_q != SWNM_H_IDLE);
    assign tick = run && (div_q == HALF_M1);
    assign rise_t = tick && !lclk_q;
    assign fall_t = tick && lclk_q;
    assign start = reg_wr && (reg_addr == `SWNM_REG_CTRL) && !run;

    // Clock lengths of each step; timed steps end on the timer instead
    always_comb begin
        len = 5'(1);
        last = 1'b0;
        case (st_q)
            SWNM_H_AIN: len = 5'(`SWNM_AIN_CLKS);
            SWNM_H_SDO: len = 5'(`SWNM_WORD_CLKS);
            SWNM_H_DIN: len = 5'(`SWNM_WORD_CLKS);
            default: len = 5'(1);
        endcase
        if (st_q == SWNM_H_ERASE || st_q == SWNM_H_WRITE) begin
            last = (tmr_q == '0);
        end else begin
            last = (bit_q == len - 5'(1));
        end
    end

    always_comb begin
        st_d = st_q;
        case (st_q)
            SWNM_H_AIN: st_d = (op_q == `SWNM_OP_READ) ? SWNM_H_READ :
                ((op_q == `SWNM_OP_EW) ? SWNM_H_DIN : SWNM_H_SET1);
            SWNM_H_READ: st_d = SWNM_H_SDO;
            SWNM_H_DIN: st_d = SWNM_H_SET1;
            SWNM_H_SET1: st_d = SWNM_H_ERASE;
            SWNM_H_ERASE: st_d = SWNM_H_SET2;
            SWNM_H_SET2: st_d = (op_q == `SWNM_OP_EW) ? SWNM_H_WRITE : SWNM_H_IDLE;
            default: st_d = SWNM_H_IDLE;
        endcase
    end

    function automatic swnm_mode_t mode_of(input swnm_hstate_t s);
        case (s)
            SWNM_H_AIN: mode_of = `SWNM_MODE_AIN;
            SWNM_H_READ: mode_of = `SWNM_MODE_READ;
            SWNM_H_SDO: mode_of = `SWNM_MODE_SDO;
            SWNM_H_DIN: mode_of = `SWNM_MODE_DIN;
            SWNM_H_SET1: mode_of = `SWNM_MODE_SETUP;
            SWNM_H_SET2: mode_of = `SWNM_MODE_SETUP;
            SWNM_H_ERASE: mode_of = `SWNM_MODE_ERASE;
            SWNM_H_WRITE: mode_of = `SWNM_MODE_WRITE;
            default: mode_of = `SWNM_MODE_STBY;
        endcase
    endfunction

    // Sequencer; after the start, modes change on the falling link edge only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= SWNM_H_IDLE;
            mode_q <= `SWNM_MODE_STBY;
            bit_q <= '0;
        end else if (start) begin
            st_q <= SWNM_H_AIN;
            mode_q <= `SWNM_MODE_AIN;
            bit_q <= '0;
        end else if (fall_t) begin
            if (last) begin
                st_q <= st_d;
                mode_q <= mode_of(st_d);
                bit_q <= '0;
            end else begin
                bit_q <= bit_q + 5'(1);
            end
        end
    end

    // Erase and write lengths in system cycles, clock kept running
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tmr_q <= '0;
        end else if (fall_t && last && st_d == SWNM_H_ERASE) begin
            tmr_q <= 22'(ERASE_CYC);
        end else if (fall_t && last && st_d == SWNM_H_WRITE) begin
            tmr_q <= 22'(WRITE_CYC);
        end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - 22'(1);
        end
    end

    // Link clock divider: 100 kHz keeps every mode inside its band
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= '0;
            lclk_q <= 1'b0;
        end else if (!run || start) begin
            div_q <= '0;
            lclk_q <= 1'b0;
        end else if (tick) begin
            div_q <= '0;
            lclk_q <= !lclk_q;
        end else begin
            div_q <= div_q + 7'(1);
        end
    end

    // Outgoing bits, MSB first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sh_q <= '0;
        end else if (start) begin
            sh_q <= {addr_q, 11'h000};
        end else if (fall_t && last && st_d == SWNM_H_DIN) begin
            sh_q <= wd_q;
        end else if (fall_t) begin
            sh_q <= {sh_q[`SWNM_DW-2:0], 1'b0};
        end
    end

    // Returned bits pass four flops before use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            i_s1_q <= 1'b1;
            i_s2_q <= 1'b1;
            i_s3_q <= 1'b1;
            io_lvl_q <= 1'b1;
        end else begin
            i_s1_q <= link.io;
            i_s2_q <= i_s1_q;
            i_s3_q <= i_s2_q;
            if (i_s2_q == i_s3_q) begin
                io_lvl_q <= i_s3_q;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= '0;
        end else if (rise_t && st_q == SWNM_H_SDO) begin
            rd_q <= {rd_q[`SWNM_DW-2:0], io_lvl_q};
        end
    end

    // Register port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_q <= `SWNM_OP_READ;
            addr_q <= '0;
            wd_q <= '0;
        end else if (reg_wr && !run) begin
            case (reg_addr)
                `SWNM_REG_CTRL: op_q <= reg_wdata[1:0];
                `SWNM_REG_ADDR: addr_q <= reg_wdata[`SWNM_AW-1:0];
                `SWNM_REG_WDATA: wd_q <= reg_wdata;
                default: op_q <= op_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `SWNM_REG_CTRL: rdata_q <= {14'h0000, op_q};
                `SWNM_REG_ADDR: rdata_q <= {11'h000, addr_q};
                `SWNM_REG_WDATA: rdata_q <= wd_q;
                `SWNM_REG_RDATA: rdata_q <= rd_q;
                `SWNM_REG_STAT: rdata_q <= {15'h0000, run};
                default: rdata_q <= 16'h0000;
            endcase
        end
    end

    assign reg_rdata = rdata_q;
    assign link.mode_sel = mode_q;
    assign link.lclk = lclk_q;
    assign link.host_io_o = sh_q[`SWNM_DW-1];
    assign link.host_io_oe = (st_q == SWNM_H_AIN) || (st_q == SWNM_H_DIN);
endmodule

// *** test/swnm_link_assertions.sv ***
// Purpose: pin-level checks on the link between host and memory
// Assumes: one clock domain; link pins sampled on clk
// Notes: frame lengths are counted in rising link clock edges
`timescale 1ns/1ps
`include "swnm_defines.svh"
module swnm_link_checker (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Link
    input wire swnm_pkg::swnm_mode_t mode_sel,
    input wire logic lclk,
    input wire logic host_io_o,
    input wire logic host_io_oe,
    input wire logic dev_io_o,
    input wire logic dev_io_oe,
    input wire logic dev_pull_en,
    input wire logic io
);
    import swnm_pkg::*;
    localparam int HALF = `SWNM_HALF_CYC;
    swnm_mode_t mode_q;
    logic lclk_q;
    logic [7:0] hi_q;
    logic [7:0] rises_q;
    logic step_end;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    assign step_end = mode_sel != mode_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= `SWNM_MODE_STBY;
            lclk_q <= 1'b0;
        end else begin
            mode_q <= mode_sel;
            lclk_q <= lclk;
        end
    end

    // Counts the samples of the present high phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_q <= 8'h00;
        end else begin
            hi_q <= lclk ? hi_q + 8'h01 : 8'h00;
        end
    end

    // Rising edges within the present step; wraps in long steps, which are not checked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rises_q <= 8'h00;
        end else if (step_end) begin
            rises_q <= 8'h00;
        end else if (lclk && !lclk_q) begin
            rises_q <= rises_q + 8'h01;
        end
    end

    a_stby_quiet: assert property ((mode_sel == `SWNM_MODE_STBY)[*8] |-> !dev_io_oe && !dev_pull_en)
        else $error("line driven or pulled in standby");
    a_ain_host_drives: assert property ((mode_sel == `SWNM_MODE_AIN)[*8] |->
        dev_pull_en && host_io_oe && !dev_io_oe && io == host_io_o)
        else $error("address-in line not pulled or not host driven");
    a_din_pulled: assert property ((mode_sel == `SWNM_MODE_DIN)[*8] |-> dev_pull_en && host_io_oe)
        else $error("data-in line not pulled");
    a_sdo_dev_drives: assert property ((mode_sel == `SWNM_MODE_SDO)[*8] |->
        dev_io_oe && !dev_pull_en && io == dev_io_o)
        else $error("data-out line not driven push-pull");
    a_read_drives: assert property ((mode_sel == `SWNM_MODE_READ)[*8] |-> dev_io_oe && !dev_pull_en)
        else $error("read does not drive the line");
    a_erase_hiz: assert property ((mode_sel == `SWNM_MODE_ERASE)[*8] |-> !dev_io_oe && !dev_pull_en)
        else $error("line not high impedance in erase");
    a_no_contention: assert property (!(dev_io_oe && host_io_oe))
        else $error("both ends drive the data line");
    a_mode_on_low: assert property (!$stable(mode_sel) |-> !lclk)
        else $error("mode changed while link clock high");
    a_bit_on_low: assert property (host_io_oe && !$stable(host_io_o) |-> !lclk)
        else $error("host data changed while link clock high");
    a_half_period: assert property ($fell(lclk) |-> hi_q == HALF)
        else $error("link clock high phase has wrong length");
    a_ain_five: assert property (step_end && mode_q == `SWNM_MODE_AIN |-> rises_q == 8'h05)
        else $error("address step not five clocks");
    a_read_one: assert property (step_end && mode_q == `SWNM_MODE_READ |-> rises_q == 8'h01)
        else $error("read step not one clock");
    a_sdo_sixteen: assert property (step_end && mode_q == `SWNM_MODE_SDO |-> rises_q == 8'h10)
        else $error("data-out step not sixteen clocks");
    a_din_sixteen: assert property (step_end && mode_q == `SWNM_MODE_DIN |-> rises_q == 8'h10)
        else $error("data-in step not sixteen clocks");
    a_setup_one: assert property (step_end && mode_q == `SWNM_MODE_SETUP |-> rises_q == 8'h01)
        else $error("setup step not one clock");
    a_erase_bracket: assert property (step_end && mode_sel == `SWNM_MODE_ERASE |->
        mode_q == `SWNM_MODE_SETUP ##1 (mode_sel == `SWNM_MODE_ERASE)[*3])
        else $error("erase not entered from setup");
    a_erase_then_setup: assert property (step_end && mode_q == `SWNM_MODE_ERASE |->
        mode_sel == `SWNM_MODE_SETUP)
        else $error("erase not followed by setup");
    a_write_after_setup: assert property (step_end && mode_sel == `SWNM_MODE_WRITE |->
        mode_q == `SWNM_MODE_SETUP)
        else $error("write not entered from setup");

    c_sdo_done: cover property (step_end && mode_q == `SWNM_MODE_SDO);
    c_erase: cover property (step_end && mode_sel == `SWNM_MODE_ERASE);
    c_write: cover property (step_end && mode_sel == `SWNM_MODE_WRITE);
endmodule

// *** test/testbench.sv ***
// Purpose: drives the host register port and checks words returned over the link
// Assumes: both ends joined by the link interface, short erase and write counts
// Notes: address and data-out bits are also captured from the pins
`timescale 1ns/1ps
`include "swnm_defines.svh"
module testbench;
    import swnm_pkg::*;
    localparam int ERASE_N = 200;
    localparam int WRITE_N = 40;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    swnm_addr_t cur_addr;
    logic armed;
    logic erase_pulse;
    logic write_pulse;
    int n_errors = 0;
    int cmp_count = 0;
    int n_erase = 0;
    int n_write = 0;
    int e0;
    int w0;
    swnm_addr_t ain_sh = 5'h00;
    swnm_word_t sdo_sh = 16'h0000;
    logic lclk_q = 1'b0;
    logic [15:0] v;

    swnm_link_if link ();

    swnm_host #(.ERASE_CYC(ERASE_N), .WRITE_CYC(WRITE_N)) i_swnm_host (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
    swnm_dev i_swnm_dev (
        .clk(clk), .resetn(resetn), .link(link), .cur_addr(cur_addr), .armed(armed),
        .erase_pulse(erase_pulse), .write_pulse(write_pulse));
    swnm_link_checker i_swnm_link_checker (
        .clk(clk), .resetn(resetn), .mode_sel(link.mode_sel), .lclk(link.lclk),
        .host_io_o(link.host_io_o), .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o),
        .dev_io_oe(link.dev_io_oe), .dev_pull_en(link.dev_pull_en), .io(link.io));

    always #50 clk = ~clk;

    // Bits as seen on the line at each rising link clock
    always @(posedge clk) begin
        lclk_q <= link.lclk;
        if (link.lclk && !lclk_q && link.mode_sel == `SWNM_MODE_AIN) begin
            ain_sh <= {ain_sh[3:0], link.io};
        end
        if (link.lclk && !lclk_q && link.mode_sel == `SWNM_MODE_SDO) begin
            sdo_sh <= {sdo_sh[14:0], link.io};
        end
        if (erase_pulse === 1'b1) begin
            n_erase <= n_erase + 1;
        end
        if (write_pulse === 1'b1) begin
            n_write <= n_write + 1;
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic go(input logic [1:0] op, input swnm_addr_t a, input swnm_word_t d);
        reg_write(`SWNM_REG_ADDR, {11'h000, a});
        reg_write(`SWNM_REG_WDATA, d);
        e0 = n_erase;
        w0 = n_write;
        reg_write(`SWNM_REG_CTRL, {14'h0000, op});
    endtask

    // Poll until idle, then compare the address and the count of array operations
    task automatic finish(input swnm_addr_t a, input int ne, input int nw);
        logic [15:0] s;
        for (int k = 0; k < 3000; k++) begin
            reg_read(`SWNM_REG_STAT, s);
            if (s[0] === 1'b0) break;
        end
        check("status idle", 16'h0000, s);
        check("address pins", {11'h000, a}, {11'h000, ain_sh});
        check("address register", {11'h000, a}, {11'h000, cur_addr});
        check("erase count", 16'(ne), 16'(n_erase - e0));
        check("write count", 16'(nw), 16'(n_write - w0));
        check("armed", 16'(ne > nw), 16'(armed));
    endtask

    task automatic write_word(input swnm_addr_t a, input swnm_word_t d);
        go(`SWNM_OP_EW, a, d);
        finish(a, 1, 1);
    endtask

    task automatic read_word(input swnm_addr_t a, input swnm_word_t exp);
        go(`SWNM_OP_READ, a, 16'h0000);
        finish(a, 0, 0);
        reg_read(`SWNM_REG_RDATA, v);
        check("read word", exp, v);
        check("data out pins", exp, sdo_sh);
        check("recirculated word", exp, i_swnm_dev.out_q);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        reg_read(`SWNM_REG_STAT, v);
        check("status after reset", 16'h0000, v);
        reg_read(`SWNM_REG_RDATA, v);
        check("read data after reset", 16'h0000, v);
        reg_read(3'h7, v);
        check("unmapped read", 16'h0000, v);
        write_word(5'h03, 16'hA5C3);
        read_word(5'h03, 16'hA5C3);
        write_word(`SWNM_LAST_ADDR, 16'h5A0F);
        write_word(5'h00, 16'hFFFF);
        read_word(5'h03, 16'hA5C3);
        read_word(`SWNM_LAST_ADDR, 16'h5A0F);
        read_word(5'h00, 16'hFFFF);
        write_word(5'h03, 16'h1234);
        read_word(5'h03, 16'h1234);
        // Writes while busy must be dropped, so the read stays on the last word
        go(`SWNM_OP_READ, `SWNM_LAST_ADDR, 16'h0000);
        reg_write(`SWNM_REG_ADDR, 16'h0003);
        finish(`SWNM_LAST_ADDR, 0, 0);
        reg_read(`SWNM_REG_RDATA, v);
        check("read after refused write", 16'h5A0F, v);
        reg_read(`SWNM_REG_ADDR, v);
        check("address kept", 16'h0014, v);
        go(`SWNM_OP_ERASE, 5'h00, 16'h0000);
        finish(5'h00, 1, 0);
        read_word(5'h03, 16'h1234);
        write_word(5'h00, 16'h0F0F);
        read_word(5'h00, 16'h0F0F);
        print_verdict();
    end
endmodule
